// file: design/jpeg_regs_pkg.sv
// constants shared by the encoder control/status register bank
// assumes a single 200 MHz pclk domain and a 32-bit APB slave
//
// How it works
// R01 - setting the encoder enable starts compression at the next frame start
// R02 - ram test bit hands output fifo and reorder rams to software
// R03 - in ram test, one write reaches all 17 rams; reads pick one ram
// R04 - control bits 14 to 2 always read as zero
// R05 - control bit 15 returns the encoder logic to its reset state
// R06 - transfer done sets status bit 0
// R07 - status bit 0 stays set until software writes one to it
// R08 - clearing bit 0 also clears bits 1 to 3; they never clear alone
// R09 - software keeps the output buffer clock running when clearing bit 0
// R10 - output fifo overflow sets bit 1 and aborts the transfer, compressed only
// R11 - spoof frame too small sets bit 2, compressed images only
// R12 - reorder buffer overflow or underflow sets bit 3
// R13 - status bits 5:4 give the output fifo watermark in quarters
// R14 - writing one to status bit 4 clears the watermark field; the code reloads it from the present fifo level
package jpeg_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h3;
  localparam logic [3:0] IDX_RAM_ADDR = 4'h4;
  localparam logic [3:0] IDX_RAM_DATA = 4'h5;

  // control fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_RAM_TEST = 1;
  localparam int CTL_SOFT_RESET = 15;

  // status fields
  localparam int ST_DONE = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_SPOOF = 2;
  localparam int ST_ROB_ERR = 3;
  localparam int ST_WMARK_LO = 4;
  localparam int NUM_FLAGS = 4;

  // ram test address fields: [9:0] word, [14:10] ram select
  localparam int RAM_WORD_W = 10;
  localparam int RAM_SEL_LSB = 10;
  localparam int RAM_SEL_W = 5;
  localparam int NUM_TEST_RAMS = 17;
  localparam int RAM_DATA_W = 16;

  // reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  localparam logic [1:0] RST_WMARK = 2'h0;

  // byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [3:0] idx);
    reg_addr = {6'h00, idx, 2'h0};
  endfunction : reg_addr

  // quarter-full watermark code of a fill level against a depth
  function automatic logic [1:0] wmark_code(input logic [31:0] level,
                                            input logic [31:0] depth);
    if (level * 4 >= depth * 3) begin
      wmark_code = 2'h3;
    end else if (level * 2 >= depth) begin
      wmark_code = 2'h2;
    end else if (level * 4 >= depth) begin
      wmark_code = 2'h1;
    end else begin
      wmark_code = 2'h0;
    end
  endfunction : wmark_code

endpackage : jpeg_regs_pkg

// file: design/frame_arm.sv
// run gate for the encoder: follows the enable bit only at frame starts
// assumes frame_start is a one-cycle pulse on pclk
`timescale 1ns/1ps
`default_nettype none
module frame_arm
  import jpeg_regs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_reset,
  input wire logic enable,
  input wire logic frame_start,
  input wire logic abort,
  output logic running
);

  // a frame already in flight is never joined midway; the gate only moves
  // on frame boundaries, while abort and soft reset stop it at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
    end else if (soft_reset || abort) begin
      running <= 1'b0; // [R05] [R10]
    end else if (frame_start) begin
      running <= enable; // [R01]
    end
  end

endmodule : frame_arm
`default_nettype wire

// file: design/fifo_watermark.sv
// peak output fifo watermark in quarters of the fifo depth
// assumes level is a same-clock count from the output fifo
`timescale 1ns/1ps
`default_nettype none
module fifo_watermark
  import jpeg_regs_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int LEVEL_W = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic [LEVEL_W-1:0] level,
  output logic [1:0] wmark
);

  logic [1:0] now_code;

  assign now_code = wmark_code(32'(level), 32'(DEPTH)); // [R13]

  // holds the highest quarter reached; a clear restarts from the present
  // level so a fill that is still high is not hidden
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wmark <= RST_WMARK;
    end else if (clear) begin
      wmark <= now_code; // [R14]
    end else if (now_code > wmark) begin
      wmark <= now_code; // [R13]
    end
  end

endmodule : fifo_watermark
`default_nettype wire

// file: design/jpeg_ctrl_status_regs.sv
// encoder control and status register bank behind an APB slave
// assumes all event inputs are one-cycle pulses on pclk; obuf_clk_on
// comes from another domain and is synchronised here
`timescale 1ns/1ps
`default_nettype none
module jpeg_ctrl_status_regs
  import jpeg_regs_pkg::*;
#(
  parameter int FIFO_DEPTH = 1024,
  parameter int LEVEL_W = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_start,
  input wire logic compressed,
  input wire logic xfer_done,
  input wire logic fifo_overflow,
  input wire logic spoof_oversize,
  input wire logic rob_error,
  input wire logic [LEVEL_W-1:0] fifo_level,
  input wire logic obuf_clk_on,
  input wire logic [NUM_TEST_RAMS*RAM_DATA_W-1:0] ram_rdata,
  output logic encoder_run,
  output logic encoder_reset,
  output logic xfer_abort,
  output logic ram_test,
  output logic [RAM_WORD_W-1:0] ram_addr,
  output logic [RAM_DATA_W-1:0] ram_wdata,
  output logic ram_we_all,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic enable;
  logic [3:0] flags;
  logic [3:0] irq_mask;
  logic [RAM_SEL_W-1:0] ram_sel;
  logic [1:0] wmark;
  logic obuf_sync1;
  logic obuf_sync2;
  logic running;
  logic access;
  logic wr_en;
  logic [3:0] idx;
  logic mapped;
  logic [3:0] set_flags;
  logic clr_flags;
  logic clr_wmark;
  logic [31:0] next_rdata;
  logic wr_ctl;
  logic wr_st;
  logic wr_msk;
  logic wr_ra;
  logic wr_rd;
  logic arm_stop;
  logic arm_enable;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state, ready is raised in the second access cycle
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite && mapped;
  assign idx = paddr[5:2];

  // one strobe per register; the decode is shared so every register sees
  // exactly the same qualifying terms
  function automatic logic write_to(input logic strobe, input logic [3:0] at,
                                    input logic [3:0] which);
    write_to = strobe && (at == which);
  endfunction : write_to

  assign wr_ctl = write_to(wr_en, idx, IDX_CONTROL);
  assign wr_st = write_to(wr_en, idx, IDX_STATUS);
  assign wr_msk = write_to(wr_en, idx, IDX_IRQ_MASK);
  assign wr_ra = write_to(wr_en, idx, IDX_RAM_ADDR);
  assign wr_rd = write_to(wr_en, idx, IDX_RAM_DATA);

  // only word-aligned addresses of the five registers answer without error
  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      mapped = (paddr == reg_addr(IDX_CONTROL)) || (paddr == reg_addr(IDX_STATUS)) ||
               (paddr == reg_addr(IDX_IRQ_MASK)) || (paddr == reg_addr(IDX_RAM_ADDR)) ||
               (paddr == reg_addr(IDX_RAM_DATA));
    end
  end

  // ready pulses for one cycle per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // error is shown together with ready for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux; registered so it stands beside ready
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (mapped) begin
      unique case (idx)
        IDX_CONTROL: begin
          next_rdata[CTL_ENABLE] = enable;
          next_rdata[CTL_RAM_TEST] = ram_test; // [R04] bits 14:2 stay zero
        end
        IDX_STATUS: begin
          next_rdata[NUM_FLAGS-1:0] = flags;
          next_rdata[ST_WMARK_LO+1:ST_WMARK_LO] = wmark; // [R13]
        end
        IDX_IRQ_MASK: begin
          next_rdata[NUM_FLAGS-1:0] = irq_mask;
        end
        IDX_RAM_ADDR: begin
          next_rdata[RAM_WORD_W-1:0] = ram_addr;
          next_rdata[RAM_SEL_LSB+RAM_SEL_W-1:RAM_SEL_LSB] = ram_sel;
        end
        IDX_RAM_DATA: begin
          // each ram reads back on its own; out-of-range selects read zero
          if (ram_test && 32'(ram_sel) < NUM_TEST_RAMS) begin
            next_rdata[RAM_DATA_W-1:0] = ram_rdata[ram_sel*RAM_DATA_W +: RAM_DATA_W]; // [R03]
          end
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data is captured in the wait state, so an event landing in the
  // access cycle shows up on the next read rather than this one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; soft reset self-clears after one cycle
  // the soft reset bit is never stored, so it always reads back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= RST_CONTROL[CTL_ENABLE];
      ram_test <= RST_CONTROL[CTL_RAM_TEST];
    end else if (wr_ctl) begin
      enable <= pwdata[CTL_ENABLE]; // [R01]
      ram_test <= pwdata[CTL_RAM_TEST]; // [R02]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encoder_reset <= RST_CONTROL[CTL_SOFT_RESET];
    end else begin
      encoder_reset <= wr_ctl && pwdata[CTL_SOFT_RESET]; // [R05]
    end
  end

  // ram test stops the gate outright, so leaving test mode never restarts
  // the encoder in the middle of a frame; it waits for the next frame start
  assign arm_stop = encoder_reset || ram_test; // [R02] [R05]
  assign arm_enable = enable && !ram_test; // [R01]

  // run gate rises only on frame boundaries; abort, soft reset and ram test stop it at once
  frame_arm u_frame_arm (
    .pclk(pclk),
    .presetn(presetn),
    .soft_reset(arm_stop),
    .enable(arm_enable),
    .frame_start(frame_start),
    .abort(xfer_abort),
    .running(running)
  );

  // the encoder is held off while software owns the rams
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encoder_run <= 1'b0;
    end else begin
      encoder_run <= running && !ram_test; // [R01] [R02]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ram test port: one data write is broadcast to all 17 rams
  // the ram select only steers readback; a data write reaches every ram
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_addr <= '0;
      ram_sel <= '0;
    end else if (wr_ra) begin
      ram_addr <= pwdata[RAM_WORD_W-1:0];
      ram_sel <= pwdata[RAM_SEL_LSB+RAM_SEL_W-1:RAM_SEL_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_wdata <= '0;
      ram_we_all <= 1'b0;
    end else begin
      ram_we_all <= wr_rd && ram_test; // [R02] [R03]
      if (wr_rd) begin
        ram_wdata <= pwdata[RAM_DATA_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer clock presence, from another domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obuf_sync1 <= 1'b0;
      obuf_sync2 <= 1'b0;
    end else begin
      obuf_sync1 <= obuf_clk_on;
      obuf_sync2 <= obuf_sync1;
    end
  end

  // overflow and spoof flags only count for compressed output
  always_comb begin
    set_flags = '0;
    set_flags[ST_DONE] = xfer_done; // [R06]
    set_flags[ST_OVERFLOW] = fifo_overflow && compressed; // [R10]
    set_flags[ST_SPOOF] = spoof_oversize && compressed; // [R11]
    set_flags[ST_ROB_ERR] = rob_error; // [R12]
  end

  // a flag clear without the output buffer clock is dropped
  assign clr_flags = wr_st && pwdata[ST_DONE] && obuf_sync2; // [R09]
  assign clr_wmark = wr_st && pwdata[ST_WMARK_LO]; // [R14]

  // one write clears all four flags; a new event in that cycle wins
  // software that clears with the buffer clock stopped simply finds the
  // flags still set and has to retry once the clock is back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= RST_FLAGS;
    end else begin
      flags <= (clr_flags ? 4'h0 : flags) | set_flags; // [R07] [R08]
    end
  end

  // overflow of a compressed image cuts the current transfer short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_abort <= 1'b0;
    end else begin
      xfer_abort <= fifo_overflow && compressed; // [R10]
    end
  end

  fifo_watermark #(
    .DEPTH(FIFO_DEPTH),
    .LEVEL_W(LEVEL_W)
  ) u_fifo_watermark (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clr_wmark),
    .level(fifo_level),
    .wmark(wmark)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt mask and level output
  // mask bits line up with the four sticky flags of the status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_msk) begin
      irq_mask <= pwdata[NUM_FLAGS-1:0];
    end
  end

  // one cycle behind the flags, as every output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irq_mask);
    end
  end

endmodule : jpeg_ctrl_status_regs
`default_nettype wire

// file: sim/jpeg_regs_chk_assertions.sv
// port checker for the encoder control/status register bank
// assumes a bind from the bench top file, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module jpeg_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_start,
  input wire logic compressed,
  input wire logic fifo_overflow,
  input wire logic encoder_run,
  input wire logic encoder_reset,
  input wire logic xfer_abort,
  input wire logic ram_test,
  input wire logic ram_we_all
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // apb answer: exactly one wait state, one-cycle strobes
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("wait state wrong");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  // run gate rises only two cycles after a frame start, and is off from the second cycle of ram test on
  run_frame_a: assert property ($rose(encoder_run) |-> $past(frame_start, 2))
    else $error("run rose mid frame");
  run_test_a: assert property (ram_test && $past(ram_test) |-> !encoder_run)
    else $error("run in ram test");
  we_test_a: assert property (ram_we_all |-> ram_test) else $error("ram write outside test");
  reset_pulse_a: assert property (encoder_reset |=> !encoder_reset)
    else $error("encoder reset held");
  // overflow abort: compressed images only, one cycle after the event
  abort_follow_a: assert property (fifo_overflow && compressed |=> xfer_abort)
    else $error("no abort");
  abort_cause_a: assert property (xfer_abort |-> $past(fifo_overflow && compressed))
    else $error("stray abort");
endmodule : jpeg_regs_chk
`default_nettype wire

// file: sim/jpeg_ctrl_status_regs_tb_top.sv
// self-checking bench for the encoder control/status register bank
// assumes default parameters; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module jpeg_ctrl_status_regs_tb_top
  import jpeg_regs_pkg::*;
;
  localparam logic [11:0] A_CTL = {6'h00, IDX_CONTROL, 2'h0};
  localparam logic [11:0] A_ST = {6'h00, IDX_STATUS, 2'h0};
  localparam logic [11:0] A_MSK = {6'h00, IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] A_RA = {6'h00, IDX_RAM_ADDR, 2'h0};
  localparam logic [11:0] A_RD = {6'h00, IDX_RAM_DATA, 2'h0};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, compressed = 0;
  logic obuf_clk_on = 0, er;
  logic [4:0] ev = 5'h00; // frame start, rob, spoof, overflow, done
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [10:0] fifo_level = 11'h000;
  logic [271:0] ram_rdata;
  wire logic [31:0] prdata;
  wire logic [9:0] ram_addr;
  wire logic [15:0] ram_wdata;
  wire logic pready, pslverr, encoder_run, encoder_reset, xfer_abort, ram_test;
  wire logic ram_we_all, irq;
  int bad_count = 0;
  int num_checks = 0;
  jpeg_ctrl_status_regs #(.FIFO_DEPTH(1024), .LEVEL_W(11)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(ev[4]), .compressed(compressed), .xfer_done(ev[0]),
    .fifo_overflow(ev[1]), .spoof_oversize(ev[2]), .rob_error(ev[3]),
    .fifo_level(fifo_level), .obuf_clk_on(obuf_clk_on), .ram_rdata(ram_rdata),
    .encoder_run(encoder_run), .encoder_reset(encoder_reset), .xfer_abort(xfer_abort),
    .ram_test(ram_test), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we_all(ram_we_all), .irq(irq));
  always #2.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  // verdict, compare and bus tasks
  task test_done;
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // the master holds the request until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      bad_count++;
      test_done;
    end
  endtask : apb
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk
  // one-cycle event pulses
  task pulse(input logic [4:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 5'h00;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_ctl_ram;
    rdchk(A_CTL, 32'h0000_0000);
    apb(1, A_CTL, 32'h0000_7FFE);
    rdchk(A_CTL, 32'h0000_0002);
    chk(ram_test, 1);
    apb(1, A_RA, 32'h0000_0C05);
    tick(1);
    chk(ram_addr, 32'h0000_0005);
    apb(1, A_RD, 32'h0000_BEEF);
    tick(1);
    chk(ram_wdata, 32'h0000_BEEF);
    chk(ram_we_all, 1);
    tick(1);
    chk(ram_we_all, 0);
    rdchk(A_RD, 32'h0000_1003);
    apb(1, A_CTL, 32'h0000_0000);
    tick(1);
    chk(ram_test, 0);
  endtask : t_ctl_ram
  // run gate: frame start, ram test takeover, soft reset pulse
  task t_run;
    apb(1, A_CTL, 32'h0000_0001);
    tick(4);
    chk(encoder_run, 0);
    pulse(5'h10);
    tick(3);
    chk(encoder_run, 1);
    apb(1, A_CTL, 32'h0000_0003);
    tick(2);
    chk(encoder_run, 0);
    apb(1, A_CTL, 32'h0000_8003);
    tick(1);
    chk(encoder_reset, 1);
    apb(1, A_CTL, 32'h0000_0001);
    rdchk(A_CTL, 32'h0000_0001);
    chk(encoder_run, 0);
  endtask : t_run
  // flags stick, clear only together and only with the buffer clock on
  task t_flags;
    pulse(5'h02);
    tick(1);
    chk(xfer_abort, 0);
    rdchk(A_ST, 32'h0000_0000);
    compressed <= 1;
    pulse(5'h0F);
    tick(1);
    chk(xfer_abort, 1);
    rdchk(A_ST, 32'h0000_000F);
    apb(1, A_ST, 32'h0000_000E);
    rdchk(A_ST, 32'h0000_000F);
    apb(1, A_ST, 32'h0000_0001);
    rdchk(A_ST, 32'h0000_000F);
    obuf_clk_on <= 1;
    tick(3);
    apb(1, A_ST, 32'h0000_0001);
    rdchk(A_ST, 32'h0000_0000);
    pulse(5'h04);
    apb(1, A_MSK, 32'h0000_0004);
    tick(2);
    chk(irq, 1);
    apb(1, A_MSK, 32'h0000_0008);
    tick(2);
    chk(irq, 0);
    apb(1, A_ST, 32'h0000_0001);
  endtask : t_flags
  // watermark boundaries, peak hold and clear
  task t_wmark;
    for (int i = 0; i < 6; i++) begin
      fifo_level <= 11'(256 * (i / 2 + 1) - ((i % 2) == 0 ? 1 : 0));
      tick(3);
      rdchk(A_ST, 32'((i + 1) / 2) << 4);
    end
    fifo_level <= 11'h000;
    tick(3);
    rdchk(A_ST, 32'h0000_0030);
    apb(1, A_ST, 32'h0000_0010);
    rdchk(A_ST, 32'h0000_0000);
  endtask : t_wmark
  task t_unmapped;
    apb(0, 12'h040, 32'h0000_0000);
    chk(er, 1);
    chk(rd, 32'h0000_0000);
  endtask : t_unmapped
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: each ram k reads back 16'h1000 plus k
  initial begin
    for (int k = 0; k < 17; k++)
      ram_rdata[16*k+:16] = 16'h1000 + 16'(k);
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rdchk(A_ST, 32'h0000_0000);
    t_ctl_ram;
    t_run;
    t_flags;
    t_wmark;
    t_unmapped;
    test_done;
  end
endmodule : jpeg_ctrl_status_regs_tb_top
bind jpeg_ctrl_status_regs jpeg_regs_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .frame_start(frame_start), .compressed(compressed), .fifo_overflow(fifo_overflow),
  .encoder_run(encoder_run), .encoder_reset(encoder_reset), .xfer_abort(xfer_abort),
  .ram_test(ram_test), .ram_we_all(ram_we_all));
`default_nettype wire
